// ===== hw/tcc_timer_core.sv
// Purpose: 16-bit timer/event counter with two capture/compare registers
// Assumes: single clk domain; CPU access is one cycle, read data next cycle
// Notes: count clock is an enable derived from clk or from input a edges
// Behaviour
// RULE1 - interval interrupt every programmed count clocks
// RULE2 - count input pulses two clocks wide
// RULE3 - capture counter at edges for widths
// RULE4 - square wave period twice programmed count
// RULE5 - PPG output with programmable cycle, width
// RULE6 - one-shot pulse of programmable width
// RULE7 - counter read-only, increments on count clock
// RULE8 - counter read holds count clock, no loss; code loses a tick at full rate or on two reads
// RULE9 - counter zero on reset or stop
// RULE10 - clear counter on input a edge
// RULE11 - clear counter on first register match
// RULE12 - soft trigger clears counter in one-shot
// RULE13 - counter read never captures second register
// RULE14 - control bit 0 selects capture or compare
// RULE15 - first register written by word only
// RULE16 - compare match raises first match interrupt
// RULE17 - input a capture edges 00,01,11; code 11 captures nothing into the first register
// RULE18 - input b capture edges 00,01,11
// RULE19 - edge select value 10 forbidden
// RULE20 - counter runs whenever mode not 00
// RULE21 - match-clear mode needs nonzero first register
// RULE22 - capture beats concurrent register read
// RULE23 - counter wraps FFFF to 0000
`timescale 1ns/1ns
`default_nettype none
`include "tcc_consts.svh"
module tcc_timer_core (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // cpu memory port
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWr,
  input wire logic busWord,
  input wire logic busRd,
  output logic [15:0] busRdData,
  // timer pins
  input wire logic timerInputA,
  input wire logic timerInputB,
  output logic timerWaveOutput,
  // match events
  output logic firstMatchIrq,
  output logic secondMatchIrq
);
  logic [1:0] rstPipe;
  logic rstN;
  logic [15:0] count, capCmpFirst, capCmpSecond;
  logic [3:1] modeCtl;
  logic ovfFlag;
  logic [2:0] ccCtl;
  logic [3:0] outCtl;
  logic [7:0] presc;
  logic [1:0] div;
  logic pendTick, oneShotArmed;
  logic aRise, aFall, bRise, bFall;

  // reset released through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'h1};
    end
  end
  assign rstN = rstPipe[1];

  // pin synchronisers
  tcc_pin_sync uSyncA (.clk(clk), .rstN(rstN), .pin(timerInputA),
    .rise(aRise), .fall(aFall));
  tcc_pin_sync uSyncB (.clk(clk), .rstN(rstN), .pin(timerInputB),
    .rise(bRise), .fall(bFall));

  // edge selection shared by all edge decodes
  function automatic logic edgeSel(input logic [1:0] es, input logic r,
                                   input logic f, input logic swap);
    logic res;
    res = 1'b0;
    case (es)
      `TCC_ES_00: res = swap ? r : f;
      `TCC_ES_01: res = swap ? f : r;
      `TCC_ES_11: res = r | f;
      default: res = 1'b0; // forbidden code, no edge; see RULE19
    endcase
    return res;
  endfunction

  // decode of fields and accesses
  wire tcc_pkg::tcc_mode_t opMode =
    tcc_pkg::tcc_mode_t'(modeCtl[`TCC_MODE_OPHI:`TCC_MODE_OPLO]);
  wire running = (opMode != tcc_pkg::TCC_STOP); // see RULE20
  wire [1:0] esA = presc[`TCC_PS_ESAHI:`TCC_PS_ESALO];
  wire [1:0] esB = presc[`TCC_PS_ESBHI:`TCC_PS_ESBLO];
  wire [1:0] ckSel = presc[`TCC_PS_CLKHI:`TCC_PS_CLKLO];
  wire aValid = edgeSel(esA, aRise, aFall, 1'b0);
  wire wrMode = busWr && (busAddr == `TCC_ADDR_MODECTL);
  wire wrCcCtl = busWr && (busAddr == `TCC_ADDR_CCCTL);
  wire wrOut = busWr && (busAddr == `TCC_ADDR_OUTCTL);
  wire wrPresc = busWr && (busAddr == `TCC_ADDR_PRESC);
  // byte writes to the word registers are ignored; see RULE15
  wire wrFirst = busWr && busWord && (busAddr == `TCC_ADDR_CCFIRST);
  wire wrSecond = busWr && busWord && (busAddr == `TCC_ADDR_CCSECOND);
  wire rdCount = busRd && (busAddr == `TCC_ADDR_COUNT);

  // count clock: divided peripheral clock or input a valid edges
  wire baseTick = (ckSel == `TCC_CK_DIV1) ? 1'b1 :
                  (ckSel == `TCC_CK_DIV2) ? div[0] :
                  (ckSel == `TCC_CK_DIV4) ? (div == `TCC_DIV4_LAST) :
                  aValid; // see RULE2
  // a read of the counter defers the tick by one clock; see RULE8
  wire wantTick = running && (baseTick || pendTick);
  wire tick = wantTick && !rdCount; // see RULE7

  // compare and clear conditions
  wire firstIsCmp = !ccCtl[`TCC_CC_FIRST_CAP]; // see RULE14
  wire secondIsCmp = !ccCtl[`TCC_CC_SECOND_CAP];
  wire matchFirst = (count == capCmpFirst);
  wire matchSecond = (count == capCmpSecond);
  wire hitFirst = tick && matchFirst; // see RULE16
  wire hitSecond = tick && matchSecond;
  wire oneShotMode = outCtl[`TCC_OUT_ONESHOT];
  wire softTrig = wrOut && busWrData[`TCC_OUT_TRIG] && oneShotMode;
  wire clrEdge = (opMode == tcc_pkg::TCC_CLR_EDGE) && aValid; // see RULE10
  wire clrMatch = (opMode == tcc_pkg::TCC_CLR_MATCH) && hitFirst;
  wire wrap = tick && (count == `TCC_MAX16);

  // capture triggers
  wire capFirstSrcA = ccCtl[`TCC_CC_FIRST_SRC];
  // code 11 on the input a path captures nothing into the first register; see RULE17
  wire capFirstA = (esA != `TCC_ES_11) && edgeSel(esA, aRise, aFall, 1'b1); // see RULE17
  wire capFirstB = edgeSel(esB, bRise, bFall, 1'b0); // see RULE18
  wire capFirst = running && !firstIsCmp &&
                  (capFirstSrcA ? capFirstA : capFirstB); // see RULE3
  // only input a edges capture into the second register; see RULE13
  wire capSecond = running && !secondIsCmp && aValid;

  // next counter value, clears before increment
  logic [15:0] next_count;
  always_comb begin
    next_count = count;
    if (!running) begin
      next_count = `TCC_RST_WORD; // see RULE9
    end else if (clrEdge || softTrig) begin
      next_count = `TCC_RST_WORD; // see RULE12
    end else if (clrMatch) begin
      next_count = `TCC_RST_WORD; // see RULE11
    end else if (tick) begin
      next_count = count + `TCC_ONE16; // wraps; see RULE23
    end
  end

  // counter, divider and deferred tick
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count <= `TCC_RST_WORD;
      div <= 2'h0;
      pendTick <= 1'b0;
    end else begin
      count <= next_count;
      div <= div + 2'h1;
      // an owed tick rides along while the base clock keeps ticking, so
      // a read at full rate is never paid back; two reads before it is paid drop one
      pendTick <= wantTick && (rdCount || (pendTick && baseTick)); // see RULE8
    end
  end

  // capture/compare registers; capture wins over cpu write
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      capCmpFirst <= `TCC_RST_WORD;
      capCmpSecond <= `TCC_RST_WORD;
    end else begin
      if (capFirst) begin
        capCmpFirst <= count; // see RULE3
      end else if (wrFirst) begin
        capCmpFirst <= busWrData; // see RULE15
      end
      if (capSecond) begin
        capCmpSecond <= count;
      end else if (wrSecond) begin
        capCmpSecond <= busWrData;
      end
    end
  end

  // control registers; overflow set wins over software clear
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      modeCtl <= 3'h0;
      ovfFlag <= 1'b0;
      ccCtl <= 3'h0;
      outCtl <= 4'h0;
      presc <= `TCC_RST_BYTE;
    end else begin
      if (wrMode) begin
        modeCtl <= busWrData[3:1];
      end
      if (wrap) begin
        ovfFlag <= 1'b1;
      end else if (wrMode) begin
        ovfFlag <= busWrData[`TCC_MODE_OVF];
      end
      if (wrCcCtl) begin
        ccCtl <= busWrData[2:0];
      end
      if (wrOut) begin
        outCtl <= busWrData[3:0] & 4'hb; // trigger bit never stored
      end
      if (wrPresc) begin
        presc <= busWrData[7:0];
      end
    end
  end

  // read mux; a coinciding capture already shows here; see RULE22
  logic [15:0] rdMux;
  always_comb begin
    case (busAddr)
      `TCC_ADDR_COUNT: rdMux = count;
      `TCC_ADDR_CCFIRST: rdMux = capFirst ? count : capCmpFirst;
      `TCC_ADDR_CCSECOND: rdMux = capSecond ? count : capCmpSecond;
      `TCC_ADDR_MODECTL: rdMux = {12'h000, modeCtl, ovfFlag};
      `TCC_ADDR_CCCTL: rdMux = {13'h0000, ccCtl};
      `TCC_ADDR_OUTCTL: rdMux = {12'h000, outCtl};
      `TCC_ADDR_PRESC: rdMux = {8'h00, presc};
      default: rdMux = `TCC_RST_WORD; // unmapped reads zero
    endcase
  end

  // wave output: square wave toggles on first match, ppg and one-shot
  // set at second match and drop at first match
  wire pulseMode = outCtl[`TCC_OUT_PPG] || oneShotMode;
  wire outSet = pulseMode && hitSecond && (!oneShotMode || oneShotArmed);
  wire outClr = pulseMode && hitFirst;
  logic next_wave;
  always_comb begin
    next_wave = timerWaveOutput;
    if (!outCtl[`TCC_OUT_EN] || !running) begin
      next_wave = 1'b0;
    end else if (outSet) begin
      next_wave = 1'b1; // see RULE5
    end else if (outClr) begin
      next_wave = 1'b0; // see RULE6
    end else if (!pulseMode && hitFirst) begin
      next_wave = !timerWaveOutput; // see RULE4
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busRdData <= `TCC_RST_WORD;
      timerWaveOutput <= `TCC_RST_OUT;
      firstMatchIrq <= `TCC_RST_OUT;
      secondMatchIrq <= `TCC_RST_OUT;
      oneShotArmed <= 1'b0;
    end else begin
      busRdData <= busRd ? rdMux : `TCC_RST_WORD;
      timerWaveOutput <= next_wave;
      firstMatchIrq <= hitFirst && firstIsCmp; // see RULE1
      secondMatchIrq <= hitSecond && secondIsCmp;
      if (softTrig) begin
        oneShotArmed <= 1'b1; // see RULE6
      end else if (outClr) begin
        oneShotArmed <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  chk_stop_clears: assert property (!running |=> count == `TCC_RST_WORD) // see RULE9
    else $error("counter not zero while stopped");
  chk_match_irq: assert property (tick && matchFirst && firstIsCmp |=> firstMatchIrq) // see RULE16
    else $error("first match did not raise interrupt");
  chk_irq_cause: assert property (firstMatchIrq |-> $past(count) == $past(capCmpFirst)) // see RULE1
    else $error("interrupt without match");
  chk_count_inc: assert property (tick && !clrEdge && !softTrig && !clrMatch
    |=> count == $past(count) + `TCC_ONE16) // see RULE7
    else $error("counter did not advance on tick");
  chk_read_hold: assert property (rdCount && wantTick && !clrEdge && !softTrig
    |=> count == $past(count) ##0 pendTick) // see RULE8
    else $error("read did not defer the tick");
  chk_edge_clear: assert property (running && clrEdge |=> count == `TCC_RST_WORD) // see RULE10
    else $error("input edge did not clear counter");
  chk_match_clear: assert property (clrMatch |=> count == `TCC_RST_WORD) // see RULE11
    else $error("match did not clear counter");
  chk_soft_trig: assert property (running && softTrig |=> count == `TCC_RST_WORD ##0 oneShotArmed) // see RULE12
    else $error("soft trigger did not restart one-shot");
  chk_cap_value: assert property (capFirst |=> capCmpFirst == $past(count)) // see RULE3
    else $error("capture missed counter value");
  chk_wrap_zero: assert property (wrap && opMode == tcc_pkg::TCC_FREE && !clrEdge && !softTrig
    |=> count == `TCC_RST_WORD && ovfFlag) // see RULE23
    else $error("counter did not wrap");
  chk_sq_toggle: assert property (outCtl[`TCC_OUT_EN] && running && !pulseMode && hitFirst
    && !($past(wrOut)) |=> timerWaveOutput != $past(timerWaveOutput)) // see RULE4
    else $error("square wave did not toggle");

  cov_match_irq: cover property (firstMatchIrq ##1 !firstMatchIrq);
  cov_capture_b: cover property (capFirst && !capFirstSrcA);
  cov_read_defer: cover property (rdCount && wantTick ##1 tick);
  cov_oneshot: cover property (softTrig ##[1:300] timerWaveOutput);
endmodule // tcc_timer_core
`default_nettype wire

// ===== hw/tcc_consts.svh
// Purpose: addresses, field positions and reset values of the timer core
// Assumes: word registers sit at their documented byte addresses
// Notes: definitions only
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
// register addresses
`define TCC_ADDR_COUNT 16'hff12
`define TCC_ADDR_CCFIRST 16'hff14
`define TCC_ADDR_CCSECOND 16'hff16
`define TCC_ADDR_MODECTL 16'hff60
`define TCC_ADDR_CCCTL 16'hff62
`define TCC_ADDR_OUTCTL 16'hff63
`define TCC_ADDR_PRESC 16'hff64
// reset values
`define TCC_RST_WORD 16'h0000
`define TCC_RST_BYTE 8'h00
`define TCC_RST_OUT 1'h0
// mode control fields
`define TCC_MODE_OVF 0
`define TCC_MODE_OPLO 2
`define TCC_MODE_OPHI 3
// capture/compare control fields
`define TCC_CC_FIRST_CAP 0
`define TCC_CC_FIRST_SRC 1
`define TCC_CC_SECOND_CAP 2
// output control fields
`define TCC_OUT_EN 0
`define TCC_OUT_ONESHOT 1
`define TCC_OUT_TRIG 2
`define TCC_OUT_PPG 3
// prescaler fields
`define TCC_PS_CLKLO 0
`define TCC_PS_CLKHI 1
`define TCC_PS_ESALO 4
`define TCC_PS_ESAHI 5
`define TCC_PS_ESBLO 6
`define TCC_PS_ESBHI 7
// edge select encodings and count clock selects
`define TCC_ES_00 2'h0
`define TCC_ES_01 2'h1
`define TCC_ES_11 2'h3
`define TCC_CK_DIV1 2'h0
`define TCC_CK_DIV2 2'h1
`define TCC_CK_DIV4 2'h2
`define TCC_DIV4_LAST 2'h3
`define TCC_ONE16 16'h0001
`define TCC_MAX16 16'hffff
`endif

// ===== hw/tcc_pkg.sv
// Purpose: shared types of the timer core
// Assumes: nothing
// Notes: enum order follows the two operating-mode bits
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_STOP,
    TCC_FREE,
    TCC_CLR_EDGE,
    TCC_CLR_MATCH
  } tcc_mode_t;
endpackage

// ===== hw/tcc_pin_sync.sv
// Purpose: three-stage synchroniser with edge pulses for one timer pin
// Assumes: pin is asynchronous to clk
// Notes: an edge is taken once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
`include "tcc_consts.svh"
module tcc_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // pin and edges
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic s1, s2, s3, level;
  wire agree = (s2 == s3);

  // s1 feeds only s2; a glitch shorter than two clocks never agrees
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1 <= `TCC_RST_OUT;
      s2 <= `TCC_RST_OUT;
      s3 <= `TCC_RST_OUT;
      level <= `TCC_RST_OUT;
      rise <= `TCC_RST_OUT;
      fall <= `TCC_RST_OUT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        level <= s3;
      end
      rise <= agree && s3 && !level; // see RULE2
      fall <= agree && !s3 && level; // see RULE2
    end
  end
endmodule // tcc_pin_sync
`default_nettype wire

// ===== dv/tcc_pin_source.sv
// Purpose: drives the two timer input pins from outside the block
// Assumes: pins are asynchronous to clk; one clk period is 100 ns
// Notes: levels always last at least two clocks, so every edge is a valid one
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_source (
  // timer pins
  output var logic pinA,
  output var logic pinB
);
  // both pins idle low from time zero
  initial begin
    pinA = 1'b0;
    pinB = 1'b0;
  end
  // set one pin and hold it for a number of clocks, never under two
  task automatic drive(input logic useB, input logic val, input int hold);
    int h;
    h = (hold < 2) ? 2 : hold;
    if (useB) begin
      pinB = val;
    end else begin
      pinA = val;
    end
    #(100 * h);
  endtask
  // a train of high pulses on input a, width clocks high and low
  task automatic pulses(input int n, input int width);
    for (int i = 0; i < n; i++) begin
      drive(1'b0, 1'b1, width);
      drive(1'b0, 1'b0, width);
    end
  endtask
endmodule // tcc_pin_source
`default_nettype wire

// ===== dv/test_timer16_capture_compare_core.sv
// Purpose: self-checking bench for the timer core
// Assumes: one-cycle bus strobes, read data one cycle after the read edge
// Notes: edge-select code 10 is never written, it is forbidden
`timescale 1ns/1ns
`default_nettype none
`include "tcc_consts.svh"
module test_timer16_capture_compare_core;
  logic clk, nrst, busWr, busWord, busRd, firstMatchIrq, secondMatchIrq, timerWaveOutput;
  logic [15:0] busAddr, busWrData, busRdData, rdv;
  wire logic pinA, pinB;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  tcc_timer_core u_dut (.clk(clk), .nrst(nrst), .busAddr(busAddr), .busWrData(busWrData),
    .busWr(busWr), .busWord(busWord), .busRd(busRd), .busRdData(busRdData),
    .timerInputA(pinA), .timerInputB(pinB), .timerWaveOutput(timerWaveOutput),
    .firstMatchIrq(firstMatchIrq), .secondMatchIrq(secondMatchIrq));
  tcc_pin_source u_src (.pinA(pinA), .pinB(pinB));
  // clock and a hang guard well beyond the whole sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      n_fail++;
      $display("Error %0t timeout", $time);
      results();
    end
  end
  task automatic results();
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error %0t %s", $time, msg);
    end
  endtask
  // one-cycle bus strobes, raised just after an edge and dropped after the next
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    busAddr = a;
    busWrData = d;
    busWord = w;
    busWr = 1'b1;
    @(posedge clk);
    #1 busWr = 1'b0;
    // one quiet edge, so the next strobe never rises in this time step
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    busAddr = a;
    busRd = 1'b1;
    @(posedge clk);
    #1 busRd = 1'b0;
    d = busRdData;
    @(posedge clk);
    #1;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // reset values and a refused byte write to the first register
  task automatic t_reset();
    rd(`TCC_ADDR_COUNT, rdv);
    chk(rdv === 16'h0000, "count reset");
    wr(`TCC_ADDR_CCFIRST, 16'h1234, 1'b0);
    rd(`TCC_ADDR_CCFIRST, rdv);
    chk(rdv === 16'h0000, "byte write taken");
  endtask
  // clear-on-match interval of six clocks, then stop clears the count
  task automatic t_interval();
    int n;
    wr(`TCC_ADDR_CCCTL, 16'h0000, 1'b0);
    wr(`TCC_ADDR_CCFIRST, 16'h0005, 1'b1);
    wr(`TCC_ADDR_PRESC, 16'h0000, 1'b0);
    wr(`TCC_ADDR_MODECTL, 16'h000c, 1'b0);
    n = 0;
    while (firstMatchIrq !== 1'b1 && n < 40) begin
      idle(1);
      n++;
    end
    n = 0;
    idle(1);
    while (firstMatchIrq !== 1'b1 && n < 40) begin
      idle(1);
      n++;
    end
    chk(n === 5, "interval period");
    rd(`TCC_ADDR_COUNT, rdv);
    chk(rdv <= 16'h0005, "count beyond match");
    wr(`TCC_ADDR_MODECTL, 16'h0000, 1'b0);
    rd(`TCC_ADDR_COUNT, rdv);
    chk(rdv === 16'h0000, "stop did not clear");
  endtask
  // five rising edges on input a as the count clock
  task automatic t_events();
    wr(`TCC_ADDR_PRESC, 16'h0013, 1'b0);
    wr(`TCC_ADDR_MODECTL, 16'h0004, 1'b0);
    u_src.pulses(5, 2);
    idle(8);
    rd(`TCC_ADDR_COUNT, rdv);
    chk(rdv === 16'h0005, "event count");
    wr(`TCC_ADDR_MODECTL, 16'h0000, 1'b0);
  endtask
  // an input a edge restarts the count from zero
  task automatic t_edge_clear();
    wr(`TCC_ADDR_PRESC, 16'h0010, 1'b0);
    wr(`TCC_ADDR_MODECTL, 16'h0008, 1'b0);
    idle(40);
    u_src.pulses(1, 3);
    rd(`TCC_ADDR_COUNT, rdv);
    chk(rdv < 16'h000c, "edge clear missing");
    wr(`TCC_ADDR_MODECTL, 16'h0000, 1'b0);
  endtask
  // a rising edge captures or not, depending on source and edge code
  task automatic cap_case(input logic [15:0] cc, input logic [15:0] ps, input logic useB,
      input logic take);
    wr(`TCC_ADDR_CCCTL, cc, 1'b0);
    wr(`TCC_ADDR_PRESC, ps, 1'b0);
    wr(`TCC_ADDR_MODECTL, 16'h0004, 1'b0);
    wr(`TCC_ADDR_CCFIRST, 16'h0000, 1'b1);
    idle(10);
    u_src.drive(useB, 1'b1, 8);
    rd(`TCC_ADDR_CCFIRST, rdv);
    chk((rdv !== 16'h0000) === take && ^rdv !== 1'bx, "capture edge");
    u_src.drive(useB, 1'b0, 8);
    wr(`TCC_ADDR_MODECTL, 16'h0000, 1'b0);
  endtask
  // clocks from a rise of the wave output to its fall, and any second match seen
  task automatic wave_high(output int w, output logic s);
    int n;
    n = 0;
    s = 1'b0;
    while (timerWaveOutput !== 1'b1 && n < 100) begin
      idle(1);
      n++;
      s = s || (secondMatchIrq === 1'b1);
    end
    w = 0;
    while (timerWaveOutput === 1'b1 && w < 100) begin
      idle(1);
      w++;
    end
  endtask
  // wave output high time in square, ppg and one-shot use
  task automatic wave_case(input logic [15:0] md, input logic [15:0] oc,
      input logic [15:0] first, input logic [15:0] second, input int width);
    int w;
    logic s;
    wr(`TCC_ADDR_CCCTL, 16'h0000, 1'b0);
    wr(`TCC_ADDR_PRESC, 16'h0000, 1'b0);
    wr(`TCC_ADDR_CCFIRST, first, 1'b1);
    wr(`TCC_ADDR_CCSECOND, second, 1'b1);
    wr(`TCC_ADDR_OUTCTL, oc, 1'b0);
    wr(`TCC_ADDR_MODECTL, md, 1'b0);
    if (oc[`TCC_OUT_ONESHOT]) begin
      idle(20);
      wr(`TCC_ADDR_OUTCTL, oc | 16'h0004, 1'b0);
      rd(`TCC_ADDR_COUNT, rdv);
      chk(rdv < 16'h0003, "soft trigger did not clear");
    end
    wave_high(w, s);
    chk(w === width, "wave high time");
    chk(s === (second != 16'hffff), "second match interrupt");
    wr(`TCC_ADDR_MODECTL, 16'h0000, 1'b0);
    wr(`TCC_ADDR_OUTCTL, 16'h0000, 1'b0);
  endtask
  // a free count runs past all ones, wraps and sets the overflow flag
  task automatic t_wrap();
    wr(`TCC_ADDR_PRESC, 16'h0000, 1'b0);
    wr(`TCC_ADDR_MODECTL, 16'h0004, 1'b0);
    idle(65540);
    rd(`TCC_ADDR_MODECTL, rdv);
    chk(rdv[`TCC_MODE_OVF] === 1'b1, "no overflow flag");
    rd(`TCC_ADDR_COUNT, rdv);
    chk(rdv < 16'h0010, "count did not wrap");
    wr(`TCC_ADDR_MODECTL, 16'h0000, 1'b0);
  endtask
  initial begin
    nrst = 1'b0;
    busAddr = 16'h0000;
    busWrData = 16'h0000;
    busWr = 1'b0;
    busWord = 1'b0;
    busRd = 1'b0;
    idle(2);
    nrst = 1'b1;
    idle(3);
    t_reset();
    t_interval();
    t_events();
    t_edge_clear();
    cap_case(16'h0003, 16'h0000, 1'b0, 1'b1);
    cap_case(16'h0003, 16'h0010, 1'b0, 1'b0);
    cap_case(16'h0001, 16'h0040, 1'b1, 1'b1);
    cap_case(16'h0001, 16'h0000, 1'b1, 1'b0);
    cap_case(16'h0003, 16'h0030, 1'b0, 1'b0);
    cap_case(16'h0001, 16'h00c0, 1'b1, 1'b1);
    wave_case(16'h000c, 16'h0001, 16'h0003, 16'hffff, 4);
    wave_case(16'h000c, 16'h0009, 16'h0009, 16'h0003, 6);
    wave_case(16'h0004, 16'h0003, 16'h0008, 16'h0003, 5);
    t_wrap();
    results();
  end
endmodule // test_timer16_capture_compare_core
`default_nettype wire
